// ===== verilog/spu_pkg.sv
// Package with constants and types for the stack pop instruction unit.
package spu_pkg;
  localparam logic [7:0] SPU_OPC_POP_R     = 8'h50;
  localparam logic [7:0] SPU_OPC_POP_IR    = 8'h51;
  localparam logic [7:0] SPU_OPC_USER_STACK_POP_DOWN     = 8'h92;
  localparam logic [7:0] SPU_OPC_USER_STACK_POP_UP     = 8'h93;
  localparam logic [7:0] SPU_ADDR_SP_HIGH  = 8'hD8;
  localparam logic [7:0] SPU_ADDR_SP_LOW   = 8'hD9;
  localparam int         SPU_INSTR_CYCLES  = 8;
  localparam logic [3:0] SPU_CYCLE_LAST    = 4'(SPU_INSTR_CYCLES - 1);
  localparam logic [7:0] SPU_ZERO_BYTE     = 8'h00;
  localparam logic [7:0] SPU_RESET_FLAGS   = 8'h00;
  localparam logic [2:0] SPU_STEP_RESET    = 3'h0;
  localparam logic [7:0] SPU_REG_CTRL      = 8'hF0;
  localparam logic [7:0] SPU_REG_STATUS    = 8'hF1;
  typedef enum logic [2:0] {
    SPU_IDLE, SPU_RD_A, SPU_RD_B, SPU_RD_DATA, SPU_WR_DST, SPU_WR_PTR, SPU_WR_PTR2, SPU_DONE
  } spu_state_t;
endpackage

// ===== verilog/spu_cycle_counter.sv
// Cycle counter that stretches each pop to its full instruction length.
`timescale 1ns/1ps
module spu_cycle_counter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control
  input  wire logic       start,
  output logic            lastCycle
);
  import spu_pkg::*;
  logic [3:0] countReg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      countReg <= 4'h0;
    end else if (start) begin
      countReg <= 4'h1;
    end else if (countReg != 4'h0 && countReg != SPU_CYCLE_LAST) begin
      countReg <= countReg + 4'h1;
    end else begin
      countReg <= 4'h0;
    end
  end

  assign lastCycle = (countReg == SPU_CYCLE_LAST);
endmodule

// ===== verilog/stack_pop_instruction_unit.sv
// Execution unit for system and user stack pop instructions.
// What this block does
// - System pop loads @stack_pointer, then increments pointer.
// - Stack pointer bytes live at D8H and D9H.
// - Pop down copies @user pointer, then decrements.
// - Pop up copies @user pointer, then increments.
// - Pops leave all condition flags unchanged.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module stack_pop_instruction_unit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Instruction issue
  input  wire logic       issueValid,
  input  wire logic [7:0] issueOpcode,
  input  wire logic [7:0] issueDst,
  input  wire logic [7:0] issueSrc,
  input  wire logic [7:0] flagsIn,
  // Register file port, read data one cycle after read strobe
  output logic [7:0]      rfAddr,
  output logic [7:0]      rfWdata,
  output logic            rfWrite,
  output logic            rfRead,
  input  wire logic [7:0] rfRdata,
  // Status
  output logic            busy,
  output logic            done,
  output logic [7:0]      flagsOut
);
  import spu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic isPop(input logic [7:0] opc);
    return opc == SPU_OPC_POP_R || opc == SPU_OPC_POP_IR || opc == SPU_OPC_USER_STACK_POP_DOWN || opc == SPU_OPC_USER_STACK_POP_UP;
  endfunction

  spu_state_t  stateReg;
  logic [7:0]  opcReg;
  logic [7:0]  dstReg;
  logic [7:0]  srcReg;
  logic [7:0]  ptrHighReg;
  logic [7:0]  ptrLowReg;
  logic [7:0]  dstAddrReg;
  logic        lastCycle;
  logic        start;
  logic        sysPop;
  logic [15:0] spNext;

  assign start  = issueValid && !busy && isPop(issueOpcode);
  assign sysPop = (opcReg == SPU_OPC_POP_R) || (opcReg == SPU_OPC_POP_IR);
  assign spNext = {ptrHighReg, ptrLowReg} + 16'h0001;

  spu_cycle_counter uCycle (
    .clk       (clk),
    .rstn      (rstn),
    .start     (start),
    .lastCycle (lastCycle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. User pops use ptrLowReg as the pointer value read from src.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateReg <= SPU_IDLE;
      opcReg   <= SPU_ZERO_BYTE;
      dstReg   <= SPU_ZERO_BYTE;
      srcReg   <= SPU_ZERO_BYTE;
    end else begin
      case (stateReg)
        SPU_IDLE: begin
          if (start) begin
            opcReg   <= issueOpcode;
            dstReg   <= issueDst;
            srcReg   <= issueSrc;
            stateReg <= SPU_RD_A;
          end
        end
        SPU_RD_A:    stateReg <= SPU_RD_B;
        SPU_RD_B:    stateReg <= SPU_RD_DATA;
        SPU_RD_DATA: stateReg <= SPU_WR_DST;
        SPU_WR_DST:  stateReg <= SPU_WR_PTR;
        SPU_WR_PTR:  stateReg <= sysPop ? SPU_WR_PTR2 : SPU_DONE;
        SPU_WR_PTR2: stateReg <= SPU_DONE;
        SPU_DONE: begin
          if (lastCycle) begin
            stateReg <= SPU_IDLE;
          end
        end
        default:     stateReg <= SPU_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file requests, at most one per state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rfAddr  <= SPU_ZERO_BYTE;
      rfWdata <= SPU_ZERO_BYTE;
      rfWrite <= 1'b0;
      rfRead  <= 1'b0;
    end else begin
      rfWrite <= 1'b0;
      rfRead  <= 1'b0;
      case (stateReg)
        SPU_IDLE: begin
          if (start) begin
            rfRead <= 1'b1;
            // System pops fetch the low byte first, so the stack read can start as early as possible.
            rfAddr <= (issueOpcode == SPU_OPC_USER_STACK_POP_DOWN || issueOpcode == SPU_OPC_USER_STACK_POP_UP) ? issueSrc : SPU_ADDR_SP_LOW;
          end
        end
        SPU_RD_A: begin
          // Only the indirect form needs its destination address fetched.
          rfRead <= (opcReg == SPU_OPC_POP_IR);
          rfAddr <= dstReg;
        end
        SPU_RD_B: begin
          // The pointer byte arrives now and is used at once as the stack read address.
          rfRead <= 1'b1;
          rfAddr <= rfRdata;
        end
        SPU_RD_DATA: begin
          // The high byte is only needed for the carry write, so it is fetched last.
          rfRead <= sysPop;
          rfAddr <= SPU_ADDR_SP_HIGH;
        end
        SPU_WR_DST: begin
          rfWrite <= 1'b1;
          rfAddr  <= dstAddrReg;
          rfWdata <= rfRdata;
        end
        SPU_WR_PTR: begin
          rfWrite <= 1'b1;
          if (sysPop) begin
            rfAddr  <= SPU_ADDR_SP_LOW;
            rfWdata <= spNext[7:0];
          end else begin
            rfAddr  <= srcReg;
            rfWdata <= (opcReg == SPU_OPC_USER_STACK_POP_DOWN) ? ptrLowReg - 8'h01 : ptrLowReg + 8'h01;
          end
        end
        SPU_WR_PTR2: begin
          rfWrite <= 1'b1;
          rfAddr  <= SPU_ADDR_SP_HIGH;
          rfWdata <= spNext[15:8];
        end
        SPU_DONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured read data. Reads return one cycle after the strobe, so each capture
  // sits two states after the state that raised the request.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptrHighReg <= SPU_ZERO_BYTE;
      ptrLowReg  <= SPU_ZERO_BYTE;
      dstAddrReg <= SPU_ZERO_BYTE;
    end else begin
      case (stateReg)
        SPU_RD_A: begin
          dstAddrReg <= dstReg;
        end
        SPU_RD_B: begin
          ptrLowReg <= rfRdata;
        end
        SPU_RD_DATA: begin
          if (opcReg == SPU_OPC_POP_IR) begin
            dstAddrReg <= rfRdata;
          end
        end
        SPU_WR_PTR: begin
          if (sysPop) begin
            ptrHighReg <= rfRdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy, done and flags. Flags pass through untouched by any pop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      flagsOut <= SPU_RESET_FLAGS;
    end else begin
      busy     <= start || (busy && !(stateReg == SPU_DONE && lastCycle));
      done     <= (stateReg == SPU_DONE) && lastCycle;
      flagsOut <= flagsIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_flags_unchanged: assert property (@(posedge clk) disable iff (!rstn)
    flagsOut == $past(flagsIn)) else $error("Flags changed by pop unit.");

  a_pop_length: assert property (@(posedge clk) disable iff (!rstn)
    start |-> ##8 done) else $error("Pop did not finish in 8 cycles.");

  a_sp_high_addr: assert property (@(posedge clk) disable iff (!rstn)
    (stateReg == SPU_WR_PTR2) |=> (rfWrite && rfAddr == SPU_ADDR_SP_HIGH)) else $error("Pointer high byte misaddressed.");

  a_sp_carry: assert property (@(posedge clk) disable iff (!rstn)
    (stateReg == SPU_WR_PTR2 && ptrLowReg == 8'hFF) |=> rfWdata == ptrHighReg + 8'h01)
    else $error("Pointer carry lost.");

  a_dst_before_ptr: assert property (@(posedge clk) disable iff (!rstn)
    (rfWrite && rfAddr == SPU_ADDR_SP_LOW && sysPop) |-> $past(rfWrite)) else $error("Pointer written before data.");

  a_user_stack_pop_down_dec: assert property (@(posedge clk) disable iff (!rstn)
    (stateReg == SPU_WR_PTR && opcReg == SPU_OPC_USER_STACK_POP_DOWN) |=> rfWdata == ptrLowReg - 8'h01)
    else $error("User pointer not decremented.");

  a_user_stack_pop_up_inc: assert property (@(posedge clk) disable iff (!rstn)
    (stateReg == SPU_WR_PTR && opcReg == SPU_OPC_USER_STACK_POP_UP) |=> rfWdata == ptrLowReg + 8'h01)
    else $error("User pointer not incremented.");
endmodule

// ===== testbench/spu_rf_model.sv
// Register file and stack memory model answering the pop unit's requests.
`timescale 1ns/1ps
module spu_rf_model (
  // Clock
  input  wire logic       clk,
  // Request port
  input  wire logic [7:0] rfAddr,
  input  wire logic [7:0] rfWdata,
  input  wire logic       rfWrite,
  input  wire logic       rfRead,
  // Answer
  output logic [7:0]      rfRdata
);
  logic [7:0] mem [0:255];
  initial rfRdata = 8'h00;
  // Outside the answer cycle the data toggle, so a late sample cannot match by luck.
  always @(posedge clk) begin
    if (rfWrite) begin
      mem[rfAddr] <= rfWdata;
    end
    if (rfRead) begin
      rfRdata <= mem[rfAddr];
    end else begin
      rfRdata <= ~rfRdata;
    end
  end
endmodule

// ===== testbench/stack_pop_instruction_unit_bench.sv
// Self-checking bench for the stack pop instruction unit.
`timescale 1ns/1ps
module stack_pop_instruction_unit_bench;
  import spu_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       issueValid = 1'b0;
  logic [7:0] issueOpcode = 8'h00;
  logic [7:0] issueDst = 8'h00;
  logic [7:0] issueSrc = 8'h00;
  logic [7:0] flagsIn = 8'h00;
  logic [7:0] rfAddr, rfWdata, rfRdata, flagsOut;
  logic       rfWrite, rfRead, busy, done;
  logic [15:0] sps [3] = '{16'h00FB, 16'h01FF, 16'hFFFF};
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  int         lat;

  stack_pop_instruction_unit dut_u (.clk(clk), .rstn(rstn), .issueValid(issueValid), .issueOpcode(issueOpcode),
    .issueDst(issueDst), .issueSrc(issueSrc), .flagsIn(flagsIn), .rfAddr(rfAddr), .rfWdata(rfWdata),
    .rfWrite(rfWrite), .rfRead(rfRead), .rfRdata(rfRdata), .busy(busy), .done(done), .flagsOut(flagsOut));
  spu_rf_model rf_u (.clk(clk), .rfAddr(rfAddr), .rfWdata(rfWdata), .rfWrite(rfWrite), .rfRead(rfRead),
    .rfRdata(rfRdata));

  initial forever #5 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Issues one instruction; a second issue is pushed in while busy when intrude is set.
  task automatic pop(input logic [7:0] opc, input logic [7:0] dst, input logic [7:0] src, input bit intrude);
    @(posedge clk);
    issueValid <= 1'b1;
    issueOpcode <= opc;
    issueDst <= dst;
    issueSrc <= src;
    flagsIn <= 8'hA5 ^ opc;
    // The issue cycle counts as the first of the instruction's cycles.
    lat = 1;
    @(posedge clk);
    issueValid <= 1'b0;
    #1;
    while (done !== 1'b1 && lat < 20) begin
      @(posedge clk);
      issueValid <= intrude && lat == 2;
      issueOpcode <= SPU_OPC_POP_R;
      #1;
      lat++;
    end
    check(16'(busy), 16'h0000, "busy released with done");
    $display("test opcode %h finished after %0d cycles", opc, lat);
  endtask

  function automatic logic [15:0] spVal();
    return {rf_u.mem[SPU_ADDR_SP_HIGH], rf_u.mem[SPU_ADDR_SP_LOW]};
  endfunction

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (sps[i]) begin
      rf_u.mem[SPU_ADDR_SP_HIGH] = sps[i][15:8];
      rf_u.mem[SPU_ADDR_SP_LOW] = sps[i][7:0];
      rf_u.mem[sps[i][7:0]] = 8'h55 + 8'(i);
      pop(SPU_OPC_POP_R, 8'h00, 8'h00, i == 1);
      check(16'(lat), 16'(SPU_INSTR_CYCLES), "pop length");
      check(16'(rf_u.mem[0]), 16'(8'h55 + 8'(i)), "popped byte");
      check(spVal(), sps[i] + 16'h0001, "stack pointer step");
      check(16'(flagsOut), 16'(8'hA5 ^ SPU_OPC_POP_R), "flags kept");
    end
    rf_u.mem[8'h01] = 8'h30;
    rf_u.mem[SPU_ADDR_SP_HIGH] = 8'h00;
    rf_u.mem[SPU_ADDR_SP_LOW] = 8'hC0;
    rf_u.mem[8'hC0] = 8'h77;
    pop(SPU_OPC_POP_IR, 8'h01, 8'h00, 1'b0);
    check(16'(lat), 16'(SPU_INSTR_CYCLES), "indirect pop length");
    check(16'(rf_u.mem[8'h30]), 16'h0077, "indirect destination");
    check(spVal(), 16'h00C1, "indirect pointer step");
    for (int i = 0; i < 2; i++) begin
      rf_u.mem[8'h00] = 8'h42;
      rf_u.mem[8'h42] = 8'h6F + 8'(i);
      pop(i == 0 ? SPU_OPC_USER_STACK_POP_DOWN : SPU_OPC_USER_STACK_POP_UP, 8'h02, 8'h00, i == 0);
      check(16'(lat), 16'(SPU_INSTR_CYCLES), "user pop length");
      check(16'(rf_u.mem[8'h02]), 16'(8'h6F + 8'(i)), "user popped byte");
      check(16'(rf_u.mem[8'h00]), i == 0 ? 16'h0041 : 16'h0043, "user pointer step");
      check(16'(flagsOut), 16'(8'hA5 ^ (i == 0 ? SPU_OPC_USER_STACK_POP_DOWN : SPU_OPC_USER_STACK_POP_UP)), "user flags");
    end
    pop(8'h70, 8'h00, 8'h00, 1'b0);
    check(16'(lat), 16'd20, "foreign opcode refused");
    check(16'(busy), 16'h0000, "idle after refusal");
    conclude();
  end
endmodule
